// [logic/gpu_perf_and_striping_regs.v]
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "gpu_perf_consts.vh"

module gpu_perf_and_striping_regs #(
  parameter ADDR_W  = 32,
  parameter BYTES_W = 8
) (
  input  wire                i_sys_clk,
  input  wire                i_rstn,
  // avalon-mm slave
  input  wire [7:0]          i_avs_address,
  input  wire                i_avs_read,
  input  wire                i_avs_write,
  input  wire [31:0]         i_avs_writedata,
  input  wire [3:0]          i_avs_byteenable,
  output reg  [31:0]         o_avs_readdata,
  output reg                 o_avs_waitrequest,
  // gpu axi traffic beats
  input  wire                i_rd_beat,
  input  wire [BYTES_W-1:0]  i_rd_beat_bytes,
  input  wire                i_wr_beat,
  input  wire [BYTES_W-1:0]  i_wr_beat_bytes,
  // access to be steered
  input  wire [ADDR_W-1:0]   i_physical_addr,
  output reg                 o_l2_cache_slice,
  output reg  [2:0]          o_sram_margin
);

  // register state; the three counters have no write path at all, so a
  // stray software write can never disturb a measurement in progress
  reg  [31:0] rd_total_reg;
  reg  [31:0] wr_total_reg;
  reg  [31:0] work_cnt_reg;
  reg  [2:0]  granule_reg;
  reg  [2:0]  granule_next;
  reg  [2:0]  margin_next;
  reg         perf_en_reg;
  reg         perf_en_next;
  reg         ack_reg;
  reg  [31:0] rdata_next;
  wire        slice_sel;
  wire        req;
  wire        wr_strobe;
  wire        cfg_wr;
  wire        ctl_wr;
  reg  [31:0] cfg_merged;
  reg  [31:0] rd_total_next;
  reg  [31:0] wr_total_next;
  reg  [31:0] work_cnt_next;

  // merge written bytes into an old value, honouring byte enables
  function [31:0] merge_be;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    integer b;
    begin
      merge_be = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) begin
          merge_be[8*b +: 8] = new_v[8*b +: 8];
        end
      end
    end
  endfunction

  // widen a beat byte count to the accumulator width
  function [31:0] grow;
    input [BYTES_W-1:0] n;
    begin
      grow = {{(32-BYTES_W){1'b0}}, n};
    end
  endfunction

  // readback image of the memory config word; reserved bits read zero
  function [31:0] cfg_word;
    input [2:0] margin;
    input [2:0] granule;
    begin
      cfg_word = {25'h0000000, margin, 1'b0, granule};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // a request is taken once; ack_reg masks the cycle in which its answer
  // stands, so a request that is still held is not taken a second time
  assign req       = (i_avs_read | i_avs_write) & ~ack_reg;
  // writes land in the answer cycle, at the edge where the master sees
  // waitrequest low, never earlier: a read issued right after the write
  // then always returns the new value
  assign wr_strobe = ack_reg & i_avs_write;
  assign cfg_wr    = wr_strobe & (i_avs_address == `OFF_MEMORY_CONFIG);
  assign ctl_wr    = wr_strobe & (i_avs_address == `OFF_PERF_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  // bus: one wait cycle, then the answer; read data is latched as the
  // request is taken, so it holds steady while waitrequest is low and
  // until the next read is taken
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      ack_reg           <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h00000000;
    end else begin
      ack_reg           <= req;
      o_avs_waitrequest <= ~req;
      if (req && i_avs_read) begin
        o_avs_readdata <= rdata_next;
      end
    end
  end

  // read decode; reserved bits and unmapped offsets read zero
  always @* begin
    case (i_avs_address)
      `OFF_RD_BYTE_TOTAL:  rdata_next = rd_total_reg;
      `OFF_WR_BYTE_TOTAL:  rdata_next = wr_total_reg;
      `OFF_WORK_CYCLE_CNT: rdata_next = work_cnt_reg;
      `OFF_MEMORY_CONFIG:  rdata_next = cfg_word(o_sram_margin,
                                                  granule_reg);
      `OFF_PERF_CONTROL:   rdata_next = {31'h00000000, perf_en_reg};
      default:             rdata_next = `UNMAPPED_READ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable fields, byte lanes honoured; writes to counters are ignored,
  // they simply have no decode here
  always @* begin
    cfg_merged   = merge_be(cfg_word(o_sram_margin, granule_reg),
                            i_avs_writedata, i_avs_byteenable);
    granule_next = granule_reg;
    margin_next  = o_sram_margin;
    perf_en_next = perf_en_reg;
    // a reserved granule code is stored as written; steering treats it
    if (cfg_wr) begin
      granule_next = cfg_merged[`GRANULE_MSB:`GRANULE_LSB];
      margin_next  = cfg_merged[`MARGIN_MSB:`MARGIN_LSB];
    end
    // only lane 0 carries the enable bit
    if (ctl_wr && i_avs_byteenable[0]) begin
      perf_en_next = i_avs_writedata[`PERF_EN_BIT];
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      granule_reg   <= `GRANULE_RESET;
      o_sram_margin <= `MARGIN_RESET;
      perf_en_reg   <= `PERF_EN_RESET;
    end else begin
      granule_reg   <= granule_next;
      o_sram_margin <= margin_next;
      perf_en_reg   <= perf_en_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next counter values; each completed beat adds its aligned byte count,
  // so a beat with partial strobes still counts in full; the sums wrap at
  // 32 bits, which software must allow for when it subtracts two readings
  always @* begin
    rd_total_next = rd_total_reg;
    wr_total_next = wr_total_reg;
    work_cnt_next = work_cnt_reg;
    if (perf_en_reg) begin
      if (i_rd_beat) begin
        rd_total_next = rd_total_reg + grow(i_rd_beat_bytes);
      end
      if (i_wr_beat) begin
        wr_total_next = wr_total_reg + grow(i_wr_beat_bytes);
      end
      work_cnt_next = work_cnt_reg + 32'h00000001;
    end
  end

  // counters hold their value whenever monitoring is off
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rd_total_reg <= `COUNTER_RESET;
      wr_total_reg <= `COUNTER_RESET;
      work_cnt_reg <= `COUNTER_RESET;
    end else begin
      rd_total_reg <= rd_total_next;
      wr_total_reg <= wr_total_next;
      work_cnt_reg <= work_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slice choice is registered so the output comes from a flip-flop;
  // a new granule steers from the access after the write's edge, and
  // the slice output lags the address it belongs to by one cycle
  l2_slice_select #(
    .ADDR_W (ADDR_W)
  ) u_slice (
    .i_granule        (granule_reg),
    .i_physical_addr  (i_physical_addr),
    .o_l2_cache_slice (slice_sel)
  );

  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_l2_cache_slice <= 1'b0;
    end else begin
      o_l2_cache_slice <= slice_sel;
    end
  end

endmodule

// [logic/gpu_perf_consts.vh]
`ifndef GPU_PERF_CONSTS_VH
`define GPU_PERF_CONSTS_VH

// register byte offsets
`define OFF_RD_BYTE_TOTAL   8'h3c
`define OFF_WR_BYTE_TOTAL   8'h40
`define OFF_WORK_CYCLE_CNT  8'h44
`define OFF_MEMORY_CONFIG   8'h60
`define OFF_PERF_CONTROL    8'h64

// memory config fields
`define GRANULE_LSB         0
`define GRANULE_MSB         2
`define MARGIN_LSB          4
`define MARGIN_MSB          6
`define GRANULE_RESET       3'h0
`define MARGIN_RESET        3'h4

// granule codes
`define GRAN_4K             3'h0
`define GRAN_128            3'h1
`define GRAN_256            3'h2
`define GRAN_512            3'h3
`define GRAN_1K             3'h4
`define GRAN_2K             3'h5
`define GRAN_RSVD           3'h6
`define GRAN_HASH           3'h7

// perf control field
`define PERF_EN_BIT         0
`define PERF_EN_RESET       1'h0

`define COUNTER_RESET       32'h00000000
`define UNMAPPED_READ       32'h00000000

`endif

// [logic/l2_slice_select.v]
`timescale 1ns/1ps
`include "gpu_perf_consts.vh"

module l2_slice_select #(
  parameter ADDR_W = 32
) (
  input  wire [2:0]        i_granule,
  input  wire [ADDR_W-1:0] i_physical_addr,
  output reg               o_l2_cache_slice
);

  // xor fold of the upper address bits above the 256 byte granule
  function hash_bit;
    input [ADDR_W-1:0] a;
    integer k;
    begin
      hash_bit = 1'b0;
      for (k = 8; k < ADDR_W; k = k + 1) begin
        hash_bit = hash_bit ^ a[k];
      end
    end
  endfunction

  // an address bit picks the slice except in hash and reserved modes; a one routes to slice one
  always @* begin
    case (i_granule)
      `GRAN_4K:   o_l2_cache_slice = i_physical_addr[12];
      `GRAN_128:  o_l2_cache_slice = i_physical_addr[7];
      `GRAN_256:  o_l2_cache_slice = i_physical_addr[8];
      `GRAN_512:  o_l2_cache_slice = i_physical_addr[9];
      `GRAN_1K:   o_l2_cache_slice = i_physical_addr[10];
      `GRAN_2K:   o_l2_cache_slice = i_physical_addr[11];
      `GRAN_HASH: o_l2_cache_slice = hash_bit(i_physical_addr);
      // reserved code: software must not use it, slice zero is a safe pick
      default:    o_l2_cache_slice = 1'b0;
    endcase
  end

endmodule

// [bench/gpu_perf_checker.sv]
`timescale 1ns/1ps
module gpu_perf_checker #(
  parameter ADDR_W = 32
) (
  input wire              i_sys_clk,
  input wire              i_rstn,
  input wire [7:0]        i_avs_address,
  input wire              i_avs_read,
  input wire              i_avs_write,
  input wire [31:0]       i_avs_writedata,
  input wire [3:0]        i_avs_byteenable,
  input wire [31:0]       o_avs_readdata,
  input wire              o_avs_waitrequest,
  input wire [ADDR_W-1:0] i_physical_addr,
  input wire              o_l2_cache_slice
);
  reg [2:0]        gran_reg, g_p;
  reg [ADDR_W-1:0] a_p;
  reg              v_p;
  // shadow granule; old value pairs with the slice launched at that edge
  always @(posedge i_sys_clk) begin
    v_p <= i_rstn;
    g_p <= gran_reg;
    a_p <= i_physical_addr;
    if (!i_rstn) gran_reg <= 3'h0;
    else if (i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h60
             && i_avs_byteenable[0]) gran_reg <= i_avs_writedata[2:0];
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////
  AST_RST_VAL: assert property (!v_p |-> o_avs_waitrequest &&
    o_avs_readdata == 32'h0 && !o_l2_cache_slice) else $error("reset");
  AST_WAIT_ONE: assert property (!o_avs_waitrequest |=>
    o_avs_waitrequest) else $error("wait low too long");
  AST_ANSWER: assert property ((i_avs_read || i_avs_write) &&
    o_avs_waitrequest |=> !o_avs_waitrequest) else $error("no answer");
  AST_GRAN_4K: assert property (v_p && g_p == 3'h0 |->
    o_l2_cache_slice == a_p[12]) else $error("4k slice");
  AST_GRAN_BYTE: assert property (v_p && g_p inside {1, 2, 3} |->
    o_l2_cache_slice == a_p[g_p + 6]) else $error("byte slice");
  AST_GRAN_KB: assert property (v_p && g_p inside {4, 5} |->
    o_l2_cache_slice == a_p[g_p + 6]) else $error("kb slice");
  AST_GRAN_HASH: assert property (v_p && g_p == 3'h7 |->
    o_l2_cache_slice == ^a_p[31:8]) else $error("hash slice");
  AST_SLICE_ONE: assert property (v_p && o_l2_cache_slice |->
    g_p != 3'h6) else $error("slice one on reserved code");
  cover property (v_p && g_p == 3'h7 && o_l2_cache_slice);
  cover property (i_avs_write && !o_avs_waitrequest);
  cover property (i_avs_read && !o_avs_waitrequest);
endmodule
bind gpu_perf_and_striping_regs gpu_perf_checker #(.ADDR_W(ADDR_W))
  gpu_perf_checker_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest),
  .i_physical_addr(i_physical_addr), .o_l2_cache_slice(o_l2_cache_slice));

// [bench/gpu_perf_and_striping_regs_tb.sv]
`timescale 1ns/1ps
module gpu_perf_and_striping_regs_tb;
  reg          i_sys_clk, i_rstn, i_avs_read, i_avs_write, en_m;
  reg          i_rd_beat, i_wr_beat;
  reg  [3:0]   i_avs_byteenable;
  reg  [7:0]   i_avs_address, i_rd_beat_bytes, i_wr_beat_bytes;
  reg  [31:0]  i_avs_writedata, i_physical_addr, rd_m, wr_m, cy_m;
  wire [31:0]  o_avs_readdata;
  wire         o_avs_waitrequest, o_l2_cache_slice;
  wire [2:0]   o_sram_margin;
  integer      seed, errors, total_checks, i;
  logic [31:0] exp_q[$];
  gpu_perf_and_striping_regs gpu_perf_and_striping_regs_i (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_rd_beat(i_rd_beat), .i_rd_beat_bytes(i_rd_beat_bytes),
    .i_wr_beat(i_wr_beat), .i_wr_beat_bytes(i_wr_beat_bytes),
    .i_physical_addr(i_physical_addr), .o_l2_cache_slice(o_l2_cache_slice),
    .o_sram_margin(o_sram_margin));
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] e);
    total_checks++;
    if (o_avs_readdata !== e) begin
      errors++;
      $display("[ERR] %0t readdata %h exp %h", $time, o_avs_readdata, e);
    end
  endtask
  task chk_margin(input logic [2:0] e);
    total_checks++;
    if (o_sram_margin !== e) begin
      errors++;
      $display("[ERR] %0t margin %h exp %h", $time, o_sram_margin, e);
    end
  endtask
  // request held until the edge that sees waitrequest low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    int n;
    i_avs_address   <= a;
    i_avs_writedata <= d;
    i_avs_read      <= !w;
    i_avs_write     <= w;
    if (!w) exp_q.push_back(e);
    for (n = 0; n < 20; n++) begin
      @(posedge i_sys_clk);
      if (!o_avs_waitrequest) break;
    end
    if (n == 20) begin
      errors++;
      $display("[ERR] %0t bus answer timeout", $time);
      report_and_stop;
    end
    if (w && a == 8'h64) en_m <= d[0];
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // random traffic always runs, so the enable gating is exercised too
  always @(posedge i_sys_clk) begin
    i_physical_addr <= $random(seed);
    {i_rd_beat, i_wr_beat} <= $random(seed);
    {i_rd_beat_bytes, i_wr_beat_bytes} <= $random(seed);
    if (!i_rstn) {rd_m, wr_m, cy_m} <= 96'h0;
    else if (en_m) begin
      cy_m <= cy_m + 32'h1;
      if (i_rd_beat) rd_m <= rd_m + i_rd_beat_bytes;
      if (i_wr_beat) wr_m <= wr_m + i_wr_beat_bytes;
    end
    if (i_avs_read && !o_avs_waitrequest) begin
      if (i_avs_address == 8'h60) chk_margin(exp_q[0][6:4]);
      chk(exp_q.pop_front());
    end
  end
  // main sequence
  initial begin
    seed = 88;
    {errors, total_checks, en_m, i_rstn, i_avs_read, i_avs_write} = 0;
    {i_avs_address, i_avs_writedata, i_physical_addr} = 0;
    i_avs_byteenable = 4'hf;
    {i_rd_beat, i_wr_beat, i_rd_beat_bytes, i_wr_beat_bytes} = 0;
    repeat (5) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    @(posedge i_sys_clk);
    bus(0, 8'h3c, 0, 32'h0);
    bus(0, 8'h40, 0, 32'h0);
    bus(0, 8'h60, 0, 32'h40);
    bus(1, 8'h3c, 32'hffffffff, 0);
    bus(0, 8'h3c, 0, 32'h0);
    bus(0, 8'h50, 0, 32'h0);
    for (i = 0; i < 8; i++) begin
      if (i != 6) begin
        bus(1, 8'h60, 32'h40 | i, 0);
        repeat (12) @(posedge i_sys_clk);
        bus(0, 8'h60, 0, 32'h40 | i);
      end
    end
    // margin moves, then a write without lane 0 must change nothing
    bus(1, 8'h60, 32'h25, 0);
    bus(0, 8'h60, 0, 32'h25);
    i_avs_byteenable <= 4'he;
    bus(1, 8'h60, 32'h07, 0);
    i_avs_byteenable <= 4'hf;
    bus(0, 8'h60, 0, 32'h25);
    bus(1, 8'h64, 1, 0);
    repeat (30) @(posedge i_sys_clk);
    bus(1, 8'h64, 0, 0);
    bus(1, 8'h44, 32'h5, 0);
    bus(0, 8'h3c, 0, rd_m);
    bus(0, 8'h40, 0, wr_m);
    bus(0, 8'h44, 0, cy_m);
    report_and_stop;
  end
endmodule
